// ==== src/smpt_exec.sv ====
// Module: combinational move, permute, test and blend datapath
`timescale 1ns/1ps
module smpt_exec
  import smpt_pkg::*;
(
  input  wire smpt_cmd_type cmd,
  input  wire logic [127:0] a,
  input  wire logic [127:0] b,
  input  wire logic [127:0] m,
  output smpt_ans_type      ans
);
  // Sign bits of four single elements
  function automatic logic [3:0] sgn_s(input logic [127:0] v);
    sgn_s = {v[127], v[95], v[63], v[31]};
  endfunction : sgn_s
  // Sign bits of two double elements
  function automatic logic [1:0] sgn_d(input logic [127:0] v);
    sgn_d = {v[127], v[63]};
  endfunction : sgn_d

  logic [3:0] sb_s;  // Single signs of the mask source
  logic [1:0] sb_d;  // Double signs of the mask source

  // Mask sign vectors, shared by loads, the double store and blend
  assign sb_s = sgn_s(b);
  assign sb_d = sgn_d(b);

  // Operation select
  always_comb
  begin
    ans = '0;
    unique case (cmd.opc)
      OPC_BCAST: ans.res = {4{m[31:0]}};
      OPC_MLD_S:
        for (int i = 0; i < 4; i++)
          ans.res[32*i +: 32] = sb_s[i] ? m[32*i +: 32] : 32'h0;
      OPC_MLD_D:
        for (int j = 0; j < 2; j++)
          ans.res[64*j +: 64] = sb_d[j] ? m[64*j +: 64] : 64'h0;
      OPC_MST_S:
      begin
        ans.res   = a;
        ans.st_en = sgn_s(b);
      end
      OPC_MST_D:
      begin
        ans.res   = a;
        ans.st_en = {{2{sb_d[1]}}, {2{sb_d[0]}}};
      end
      OPC_PRV_S:
        for (int i = 0; i < 4; i++)
          ans.res[32*i +: 32] = a[32*b[32*i +: 2] +: 32];
      OPC_PRV_D:
        for (int j = 0; j < 2; j++)
          ans.res[64*j +: 64] = a[64*b[64*j+PERMD_BIT] +: 64];
      OPC_PRI_S:
        for (int i = 0; i < 4; i++)
          ans.res[32*i +: 32] = a[32*cmd.imm[2*i +: 2] +: 32];
      OPC_PRI_D:
        for (int j = 0; j < 2; j++)
          ans.res[64*j +: 64] = a[64*cmd.imm[j] +: 64];
      OPC_TST_S:
      begin
        ans.flg_we = 1'b1;
        ans.zf     = ~|(sgn_s(b) & sgn_s(a));
        ans.cf     = ~|(sgn_s(b) & ~sgn_s(a));
      end
      OPC_TST_D:
      begin
        ans.flg_we = 1'b1;
        ans.zf     = ~|(sgn_d(b) & sgn_d(a));
        ans.cf     = ~|(sgn_d(b) & ~sgn_d(a));
      end
      OPC_BLEND:
        for (int i = 0; i < 4; i++)
          ans.res[32*i +: 32] = sb_s[i] ? m[32*i +: 32] : a[32*i +: 32];
      // Legacy move passes first source
      OPC_LEGCY: ans.res = a;
      // Control ops and illegal codes
      default: ans = '0;
    endcase
  end
endmodule : smpt_exec

// ==== src/smpt_pkg.sv ====
// Package: constants and types of the vector move/permute/test unit
// Functional notes
// - broadcast one 32-bit element to four
// - masked load of single or double elements
// - masked store of single or double elements
// - only mask-selected elements are transferred
// - variable permute, controls from second register
// - immediate permute, controls from imm8 byte
// - zero flag from AND of sign bits
// - carry flag from AND-NOT sign bits
// - double test looks at 64-bit signs
// - variable blend only explicit mask form
// - no prefix form for legacy media ops
// - legacy ops: 128-bit form, no 256-bit
// - fault unless OS enabled wide state
// - enable reg bits 2,1 both required
// - control read index 0, hi/lo split
// - feature bit 27 reports OS enable
// - feature bit 28 reports hardware support
// - OS flag implies save, restore, read
// - feature bit 26 is hardware only
// - control write only at privilege zero
// - same gating for prefixed 128-bit ops
package smpt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_FEAT = 8'h08;
  localparam logic [7:0] OFS_SYSC = 8'h0C;
  localparam logic [7:0] OFS_XLO  = 8'h10;
  localparam logic [7:0] OFS_XHI  = 8'h14;
  localparam logic [7:0] OFS_RDLO = 8'h18;
  localparam logic [7:0] OFS_RDHI = 8'h1C;
  localparam logic [7:0] OFS_SRCA = 8'h20;
  localparam logic [7:0] OFS_SRCB = 8'h30;
  localparam logic [7:0] OFS_MEM  = 8'h40;
  localparam logic [7:0] OFS_RES  = 8'h50;
  // Control field positions
  localparam int CTRL_IMM  = 8;
  localparam int CTRL_WIDE = 16;
  localparam int CTRL_PFX  = 17;
  localparam int CTRL_MED  = 18;
  localparam int CTRL_IMPL = 19;
  localparam int CTRL_PRIV = 20;
  localparam int CTRL_IDX  = 24;
  localparam int CTRL_GO   = 31;
  // Status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ZF   = 2;
  localparam int STAT_CF   = 3;
  localparam int STAT_UD   = 4;
  // Feature report bit positions
  localparam int FEAT_SAVE = 26;
  localparam int FEAT_OSEN = 27;
  localparam int FEAT_WIDE = 28;
  // Enable register bits: narrow and wide state
  localparam int XEN_NARROW = 1;
  localparam int XEN_WIDE   = 2;
  // Double permute control bit inside each qword
  localparam int PERMD_BIT = 1;
  // Reset values and hardware capability
  localparam logic [63:0] RST_XCR  = 64'h0000_0000_0000_0001;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic        HW_WIDE  = 1'b1;
  localparam logic        HW_SAVE  = 1'b1;
  // Opcodes
  localparam logic [3:0] OPC_BCAST = 4'h0;
  localparam logic [3:0] OPC_MLD_S = 4'h1;
  localparam logic [3:0] OPC_MLD_D = 4'h2;
  localparam logic [3:0] OPC_MST_S = 4'h3;
  localparam logic [3:0] OPC_MST_D = 4'h4;
  localparam logic [3:0] OPC_PRV_S = 4'h5;
  localparam logic [3:0] OPC_PRV_D = 4'h6;
  localparam logic [3:0] OPC_PRI_S = 4'h7;
  localparam logic [3:0] OPC_PRI_D = 4'h8;
  localparam logic [3:0] OPC_TST_S = 4'h9;
  localparam logic [3:0] OPC_TST_D = 4'hA;
  localparam logic [3:0] OPC_BLEND = 4'hB;
  localparam logic [3:0] OPC_XRD   = 4'hC;
  localparam logic [3:0] OPC_XWR   = 4'hD;
  localparam logic [3:0] OPC_LEGCY = 4'hE;
  // Command carried to the datapath
  typedef struct packed {
    logic [3:0] opc;
    logic [7:0] imm;
  } smpt_cmd_type;
  // Datapath answer
  typedef struct packed {
    logic [127:0] res;
    logic [3:0]   st_en;
    logic         flg_we;
    logic         zf;
    logic         cf;
  } smpt_ans_type;
endpackage : smpt_pkg

// ==== src/smpt_top.sv ====
// Module: APB register front and sequencer of the vector unit
`timescale 1ns/1ps
module smpt_top
  import smpt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             fault
);
  // Sequencer states
  typedef enum logic {ST_IDLE, ST_EXEC} smpt_st_type;

  smpt_st_type  st_r;        // Sequencer state
  logic [31:0]  ctrl_r;      // Command register
  logic         os_en_r;     // OS save enable flag
  logic [63:0]  xcr_r;       // State enable register
  logic [63:0]  rd_r;        // Control read result
  logic [31:0]  a_r [4];     // First source words
  logic [31:0]  b_r [4];     // Mask or control words
  logic [31:0]  m_r [4];     // Memory operand words
  logic [31:0]  res_r [4];   // Destination words
  logic         done_r;      // Completion flag
  logic         zf_r;        // Zero result flag
  logic         cf_r;        // Carry result flag
  logic         ud_r;        // Invalid opcode fault
  logic [31:0]  prdata_r;    // Read data
  logic         pready_r;    // Access ready
  logic         pslverr_r;   // Access error
  smpt_cmd_type cmd;         // Latched command
  smpt_ans_type ans;         // Datapath answer
  logic         ud_nxt;      // Fault of current command
  logic         setup;       // APB setup cycle
  logic         wr_go;       // Write taking effect
  logic         start;       // Command launch

  // Word of a 4-word group at base
  function automatic logic hit(input logic [7:0] ad,
                               input logic [7:0] base);
    hit = (ad[7:4] == base[7:4]);
  endfunction : hit

  // Pack four words
  function automatic logic [127:0] pk(input logic [31:0] w [4]);
    pk = {w[3], w[2], w[1], w[0]};
  endfunction : pk

  // Wide state usable by software
  function automatic logic wide_ok(input logic os,
                                   input logic [63:0] x);
    wide_ok = os & x[XEN_NARROW] & x[XEN_WIDE];
  endfunction : wide_ok

  // Bus phase decode
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign start = wr_go & (paddr == OFS_CTRL) & pwdata[CTRL_GO]
               & (st_r == ST_IDLE);

  // Command toward the datapath
  assign cmd.opc = ctrl_r[3:0];
  assign cmd.imm = ctrl_r[CTRL_IMM +: 8];

  // Datapath
  smpt_exec u_exec (
    .cmd (cmd),
    .a   (pk(a_r)),
    .b   (pk(b_r)),
    .m   (pk(m_r)),
    .ans (ans)
  );

  // Fault decision for the latched command
  always_comb
  begin
    ud_nxt = 1'b0;
    unique case (cmd.opc)
      OPC_XRD:
        ud_nxt = ~os_en_r | (ctrl_r[CTRL_IDX +: 4] != 4'h0);
      OPC_XWR:
        ud_nxt = ~os_en_r | (ctrl_r[CTRL_PRIV +: 2] != 2'h0)
               | (ctrl_r[CTRL_IDX +: 4] != 4'h0);
      OPC_LEGCY:
      begin
        if (ctrl_r[CTRL_PFX] & ctrl_r[CTRL_MED])
          ud_nxt = 1'b1;
        if (ctrl_r[CTRL_WIDE])
          ud_nxt = 1'b1;
        if (ctrl_r[CTRL_PFX] & ~(HW_WIDE & wide_ok(os_en_r, xcr_r)))
          ud_nxt = 1'b1;
      end
      OPC_BCAST, OPC_MLD_S, OPC_MLD_D, OPC_MST_S, OPC_MST_D,
      OPC_PRV_S, OPC_PRV_D, OPC_PRI_S, OPC_PRI_D, OPC_TST_S,
      OPC_TST_D, OPC_BLEND:
      begin
        ud_nxt = ~(HW_WIDE & wide_ok(os_en_r, xcr_r));
        if ((cmd.opc == OPC_BLEND) & ctrl_r[CTRL_IMPL])
          ud_nxt = 1'b1;
      end
      // Unassigned opcode
      default: ud_nxt = 1'b1;
    endcase
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ST_IDLE;
    else if (ce)
    begin
      unique case (st_r)
        ST_IDLE: if (start) st_r <= ST_EXEC;
        ST_EXEC: st_r <= ST_IDLE;
      endcase
    end
  end

  // Command register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= RST_CTRL;
    else if (ce && wr_go && paddr == OFS_CTRL && st_r == ST_IDLE)
      ctrl_r <= pwdata;
  end

  // OS save enable, only where saving exists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      os_en_r <= 1'b0;
    else if (ce && wr_go && paddr == OFS_SYSC)
      os_en_r <= pwdata[0] & HW_SAVE;
  end

  // State enable register, written by control write only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xcr_r <= RST_XCR;
    else if (ce && st_r == ST_EXEC && cmd.opc == OPC_XWR && !ud_nxt)
      xcr_r <= {b_r[0], a_r[0]};
  end

  // Control read result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_r <= '0;
    else if (ce && st_r == ST_EXEC && cmd.opc == OPC_XRD && !ud_nxt)
      rd_r <= xcr_r;
  end

  // Source registers from software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        a_r[i] <= '0;
        b_r[i] <= '0;
      end
    end
    else if (ce && wr_go)
    begin
      if (hit(paddr, OFS_SRCA))
        a_r[paddr[3:2]] <= pwdata;
      if (hit(paddr, OFS_SRCB))
        b_r[paddr[3:2]] <= pwdata;
    end
  end

  // Memory operand: software fill and masked store
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        m_r[i] <= '0;
    end
    else if (ce)
    begin
      if (wr_go && hit(paddr, OFS_MEM))
        m_r[paddr[3:2]] <= pwdata;
      if (st_r == ST_EXEC && !ud_nxt)
        for (int i = 0; i < 4; i++)
          if (ans.st_en[i])
            m_r[i] <= ans.res[32*i +: 32];
    end
  end

  // Destination register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        res_r[i] <= '0;
    end
    else if (ce && st_r == ST_EXEC && !ud_nxt)
    begin
      // Stores, tests and control ops keep it
      if (cmd.opc != OPC_MST_S && cmd.opc != OPC_MST_D &&
          !ans.flg_we && cmd.opc != OPC_XRD && cmd.opc != OPC_XWR)
        for (int i = 0; i < 4; i++)
          res_r[i] <= ans.res[32*i +: 32];
    end
  end

  // Result flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zf_r <= 1'b0;
      cf_r <= 1'b0;
    end
    else if (ce && st_r == ST_EXEC && !ud_nxt && ans.flg_we)
    begin
      zf_r <= ans.zf;
      cf_r <= ans.cf;
    end
  end

  // Completion and fault status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_r <= 1'b0;
      ud_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (st_r == ST_EXEC)
      begin
        // Set over any clear in this cycle
        done_r <= 1'b1;
        ud_r   <= ud_nxt;
      end
      else if (start)
      begin
        done_r <= 1'b0;
        ud_r   <= 1'b0;
      end
    end
  end

  // Busy output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else if (ce)
      busy <= start | (busy & st_r != ST_EXEC);
  end

  // Read mux for the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (ce && setup)
    begin
      prdata_r <= '0;
      if (hit(paddr, OFS_SRCA))
        prdata_r <= a_r[paddr[3:2]];
      else if (hit(paddr, OFS_SRCB))
        prdata_r <= b_r[paddr[3:2]];
      else if (hit(paddr, OFS_MEM))
        prdata_r <= m_r[paddr[3:2]];
      else if (hit(paddr, OFS_RES))
        prdata_r <= res_r[paddr[3:2]];
      else
      begin
        unique case (paddr)
          OFS_CTRL: prdata_r <= ctrl_r;
          OFS_STAT:
          begin
            prdata_r[STAT_BUSY] <= st_r == ST_EXEC;
            prdata_r[STAT_DONE] <= done_r;
            prdata_r[STAT_ZF]   <= zf_r;
            prdata_r[STAT_CF]   <= cf_r;
            prdata_r[STAT_UD]   <= ud_r;
          end
          OFS_FEAT:
          begin
            prdata_r[FEAT_SAVE] <= HW_SAVE;
            prdata_r[FEAT_OSEN] <= os_en_r;
            prdata_r[FEAT_WIDE] <= HW_WIDE;
          end
          OFS_SYSC: prdata_r[0] <= os_en_r;
          OFS_XLO:  prdata_r <= xcr_r[31:0];
          OFS_XHI:  prdata_r <= xcr_r[63:32];
          OFS_RDLO: prdata_r <= rd_r[31:0];
          OFS_RDHI: prdata_r <= rd_r[63:32];
          default:  prdata_r <= '0;
        endcase
      end
    end
  end

  // Ready one cycle after setup, error on bad address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ((paddr[1:0] != 2'h0) | (paddr > 8'h5C)
                 | (pwrite & (paddr == OFS_STAT || paddr == OFS_FEAT
                 || paddr == OFS_XLO || paddr == OFS_XHI
                 || paddr == OFS_RDLO || paddr == OFS_RDHI
                 || hit(paddr, OFS_RES))));
    end
  end

  // Output drive
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign fault   = ud_r;
endmodule : smpt_top

// ==== test/smpt_sva.sv ====
// Checker of bus timing, command busy and fault of the vector unit
`timescale 1ns/1ps
module smpt_sva
  import smpt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy,
  input wire logic        fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle seen by the slave
  wire setup_w = psel && !penable && ce;
  // Accepted start of a command
  wire go_w    = psel && penable && pready && pwrite && ce && paddr == OFS_CTRL
                 && pwdata[CTRL_GO] && !busy;
  property p_ack; setup_w |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  property p_noack; ce && !setup_w |=> !pready; endproperty
  a_noack: assert property (p_noack) else $error("ready without setup");
  property p_err_ack; pslverr |-> pready; endproperty
  a_err_ack: assert property (p_err_ack) else $error("error without ready");
  property p_bad_adr; setup_w && (paddr[1:0] != 2'h0 || paddr > 8'h5C) |=> pslverr; endproperty
  a_bad_adr: assert property (p_bad_adr) else $error("bad address not refused");
  property p_ro_wr;
    setup_w && pwrite && paddr inside {8'h04, 8'h08, [8'h10:8'h1C], [8'h50:8'h5C]} |=> pslverr;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write not refused");
  property p_ok_rd;
    setup_w && !pwrite && paddr[1:0] == 2'h0 && paddr <= 8'h5C |=> pready && !pslverr;
  endproperty
  a_ok_rd: assert property (p_ok_rd) else $error("good read refused");
  property p_go; go_w |=> busy; endproperty
  a_go: assert property (p_go) else $error("busy not one cycle after start");
  property p_busy; busy && ce |=> !busy; endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
  // Clock enable low freezes the ready, error, busy and fault outputs
  property p_freeze;
    !ce |=> $stable(pready) && $stable(pslverr) && $stable(busy) && $stable(fault);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
  property p_fault; $changed(fault) |-> busy || $past(busy); endproperty
  a_fault: assert property (p_fault) else $error("fault moved outside command");
  // Main scenarios reached
  c_go: cover property (go_w ##2 !busy);
  c_fault: cover property ($rose(fault));
  c_err: cover property (pslverr);
endmodule : smpt_sva

bind smpt_top smpt_sva chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .busy(busy), .fault(fault));

// ==== test/smpt_top_tb.sv ====
// Self-checking bench of the vector move, permute and test unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module smpt_top_tb
  import smpt_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;  // Clock enable, on except in the clock enable hold test
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, busy, fault;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] seed = 32'hDEC6;  // Random state
  localparam logic [127:0] SGN_S = {4{32'h8000_0000}};
  localparam logic [127:0] SGN_D = {2{64'h8000_0000_0000_0000}};
  // Addresses that must be refused on write
  logic [7:0]  bad [9] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h50, 8'h02, 8'h60};

  smpt_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .fault(fault));

  // Clock of 10 ns
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected result of data ops
  function automatic logic [127:0] model(input logic [3:0] op, input logic [7:0] im,
                                         input logic [127:0] a, b, m);
    logic [127:0] r;
    r = a;
    for (int i = 0; i < 4; i++)
      case (op)
        OPC_BCAST: r[32*i+:32] = m[31:0];
        OPC_MLD_S: r[32*i+:32] = b[32*i+31] ? m[32*i+:32] : 32'h0;
        OPC_MST_S: r[32*i+:32] = b[32*i+31] ? a[32*i+:32] : m[32*i+:32];
        OPC_PRV_S: r[32*i+:32] = a[32*b[32*i+:2]+:32];
        OPC_PRI_S: r[32*i+:32] = a[32*im[2*i+:2]+:32];
        default: ;
      endcase
    for (int i = 0; i < 2; i++)
      case (op)
        OPC_MLD_D: r[64*i+:64] = b[64*i+63] ? m[64*i+:64] : 64'h0;
        OPC_MST_D: r[64*i+:64] = b[64*i+63] ? a[64*i+:64] : m[64*i+:64];
        OPC_PRV_D: r[64*i+:64] = a[64*b[64*i+PERMD_BIT]+:64];
        OPC_PRI_D: r[64*i+:64] = a[64*im[i]+:64];
        default: ;
      endcase
    return r;
  endfunction : model

  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, ad, d, q, er);
    `CHK("write err", 1'b0, er)
  endtask : wr

  task automatic rd32(input logic [7:0] ad, output logic [31:0] d);
    logic er;
    apb(1'b0, ad, 32'h0, d, er);
    `CHK("read err", 1'b0, er)
  endtask : rd32

  task automatic wr4(input logic [7:0] ba, input logic [127:0] v);
    for (int i = 0; i < 4; i++) wr(ba + 8'(4 * i), v[32*i+:32]);
  endtask : wr4

  task automatic rd4(input logic [7:0] ba, output logic [127:0] v);
    logic [31:0] w;
    for (int i = 0; i < 4; i++)
    begin
      rd32(ba + 8'(4 * i), w);
      v[32*i+:32] = w;
    end
  endtask : rd4

  // Start a command and check its completion status
  task automatic run(input logic [31:0] ctl, input logic ud, output logic [31:0] st);
    wr(OFS_CTRL, ctl | 32'h8000_0000);
    rd32(OFS_STAT, st);
    `CHK("done", 1'b1, st[STAT_DONE])
    `CHK("busy bit", 1'b0, st[STAT_BUSY])
    `CHK("fault bit", ud, st[STAT_UD])
    `CHK("fault pin", ud, fault)
  endtask : run

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    logic [31:0]  d, st;
    logic [127:0] a, b, m, v;
    logic [3:0]   op;
    logic [7:0]   im;
    logic         er;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd32(OFS_FEAT, d);
    `CHK("feat", {3'h0, HW_WIDE, 1'b0, HW_SAVE, 26'h0}, d)
    run(32'(OPC_BCAST), 1'b1, st);
    run(32'(OPC_XRD), 1'b1, st);
    wr(OFS_SYSC, 32'h1);
    rd32(OFS_FEAT, d);
    `CHK("feat os", 1'b1, d[FEAT_OSEN])
    run(32'(OPC_XRD), 1'b0, st);
    rd32(OFS_RDLO, d);
    `CHK("rd lo", RST_XCR[31:0], d)
    rd32(OFS_RDHI, d);
    `CHK("rd hi", RST_XCR[63:32], d)
    run(32'(OPC_XRD) | 32'h0100_0000, 1'b1, st);
    run(32'(OPC_BCAST), 1'b1, st);
    wr4(OFS_SRCB, '0);
    wr4(OFS_SRCA, 128'h7);
    run(32'(OPC_XWR) | 32'h0010_0000, 1'b1, st);
    rd32(OFS_XLO, d);
    `CHK("enable kept", RST_XCR[31:0], d)
    for (int i = 1; i < 4; i++)
    begin
      wr4(OFS_SRCA, 128'(2 * i + 1));
      run(32'(OPC_XWR), 1'b0, st);
      rd32(OFS_XLO, d);
      `CHK("enable reg", 32'(2 * i + 1), d)
      run(32'(OPC_BCAST), i != 3, st);
    end
    $display("test gating done");
    foreach (bad[i])
    begin
      apb(1'b1, bad[i], 32'hFFFF_FFFF, d, er);
      `CHK("refused", 1'b1, er)
    end
    rd32(OFS_XLO, d);
    `CHK("enable reg", 32'h7, d)
    $display("test bus errors done");
    for (int k = 0; k < 33; k++)
    begin
      op = 4'(k % 11);
      im = 8'(rnd());
      a = {rnd(), rnd(), rnd(), rnd()};
      b = (k > 21) ? '0 : {rnd(), rnd(), rnd(), rnd()};
      m = {rnd(), rnd(), rnd(), rnd()};
      wr4(OFS_SRCA, a);
      wr4(OFS_SRCB, b);
      wr4(OFS_MEM, m);
      run({16'h0, im, 4'h0, op}, 1'b0, st);
      if (op >= OPC_TST_S)
      begin
        v = (op == OPC_TST_S) ? SGN_S : SGN_D;
        `CHK("zero flag", ~|(a & b & v), st[STAT_ZF])
        `CHK("carry flag", ~|(b & ~a & v), st[STAT_CF])
      end
      else
      begin
        rd4((op == OPC_MST_S || op == OPC_MST_D) ? OFS_MEM : OFS_RES, v);
        `CHK("result", model(op, im, a, b, m), v)
      end
    end
    $display("test data ops done");
    wr4(OFS_SRCB, '1);
    run(32'(OPC_BLEND) | 32'h0008_0000, 1'b1, st);
    run(32'(OPC_BLEND), 1'b0, st);
    rd4(OFS_RES, v);
    `CHK("blend", m, v)
    run(32'(OPC_LEGCY) | 32'h0003_0000, 1'b1, st);
    run(32'(OPC_LEGCY) | 32'h0006_0000, 1'b1, st);
    rd4(OFS_RES, v);
    `CHK("result kept", m, v)
    run(32'(OPC_LEGCY) | 32'h0002_0000, 1'b0, st);
    rd4(OFS_RES, v);
    `CHK("legacy move", a, v)
    run(32'hF, 1'b1, st);
    // Clock enable low holds a pending broadcast
    fork
      wr(OFS_CTRL, 32'h8000_0000 | 32'(OPC_BCAST));
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("busy held", 1'b1, busy)
        ce <= 1'b1;
      end
    join
    @(posedge pclk);
    rd32(OFS_STAT, st);
    `CHK("done after hold", 1'b1, st[STAT_DONE])
    `CHK("fault after hold", 1'b0, fault)
    rd4(OFS_RES, v);
    `CHK("bcast after hold", model(OPC_BCAST, 8'h00, a, b, m), v)
    $display("test clock enable done");
    wr(OFS_SYSC, 32'h0);
    run(32'(OPC_PRV_S) | 32'h0002_0000, 1'b1, st);
    $display("test encodings done");
    close_out();
  end
endmodule : smpt_top_tb
